// ==== tgi0_params.svh ====
`ifndef TGI0_PARAMS_SVH
`define TGI0_PARAMS_SVH

// Register byte offsets.
`define TGI0_OFS_CONTROL      12'h100
`define TGI0_OFS_ADDRESS      12'h104

// Control register field positions.
`define TGI0_CTL_ENABLE_BIT   31
`define TGI0_CTL_BLKSZ_HI     27
`define TGI0_CTL_BLKSZ_LO     24
`define TGI0_CTL_PREFETCH_BIT 23
`define TGI0_CTL_BURSTWR_BIT  22
`define TGI0_CTL_INVERT_BIT   20
`define TGI0_CTL_TCODE_HI     15
`define TGI0_CTL_TCODE_LO     12
`define TGI0_CTL_PSIZE_HI     11
`define TGI0_CTL_PSIZE_LO     10
`define TGI0_CTL_POSTWR_BIT   7
`define TGI0_CTL_SPACE_BIT    6

// Address register field positions.
`define TGI0_ADR_BASE_HI      31
`define TGI0_ADR_BASE_LO      16
`define TGI0_ADR_XLAT_HI      15
`define TGI0_ADR_XLAT_LO      0

// Reset values.
`define TGI0_RST_BIT          1'h0
`define TGI0_RST_BLKSZ        4'h0
`define TGI0_RST_TCODE        4'h0
`define TGI0_RST_PSIZE        2'h0
`define TGI0_RST_HALF         16'h0000
`define TGI0_RST_WORD         32'h0000_0000

// Smallest window is 64 Kbytes: PCI address bits below 16 are never compared.
`define TGI0_MIN_WIN_SHIFT    16

`endif

// ==== tgi0_pkg.sv ====
`default_nettype none
package tgi0_pkg;

    typedef enum logic [1:0] {
        TGI0_PORT_32   = 2'h0,
        TGI0_PORT_8    = 2'h1,
        TGI0_PORT_16   = 2'h2,
        TGI0_PORT_RSVD = 2'h3
    } tgi0_psize_e;

    typedef logic [15:0] tgi0_half_t;

endpackage : tgi0_pkg
`default_nettype wire

// ==== tgi0_regs.sv ====
// Operation
// - window is 64 Kbytes times two to code
// - invert bit flips the local byte order setting
// - port size 00 32-bit, 01 8-bit, 10 16-bit
// - space bit 0 memory, 1 I/O
// - post only memory-space writes, never I/O
// - block size and space loadable from EEPROM
// - EEPROM-loaded fields read-only unless strap override
// - loaded space bit matches base-address config register
// - no load: fields reset zero and writable
// - no load, strap low: base-address config register disabled
// - strap high lets local bus write fields
// - control register byte layout as documented
// - address register: base high, translation low
// - compare address bits 31 down to 16 plus code
// - base address supplies compared upper address bits
// - writable base address reads zero after PCI reset
`default_nettype none
`include "tgi0_params.svh"

module tgi0_regs
    import tgi0_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        pci_rst,
    input  wire logic        pci_disable_strap,
    input  wire logic        eeprom_load_strobe,
    input  wire logic [3:0]  eeprom_block_size_code,
    input  wire logic        eeprom_pci_address_space,
    input  wire logic        eeprom_cfg_enable,
    input  wire logic [15:0] pci_base_addr_cfg0,
    input  wire logic        local_byte_order_setting,
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [3:0]  reg_be,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,
    input  wire logic [31:0] pci_addr,
    input  wire logic        pci_addr_valid,
    input  wire logic        pci_io_cycle,
    input  wire logic        pci_write_cycle,
    output logic             image_hit,
    output logic             post_write_ok,
    output logic      [31:0] local_addr,
    output logic             image_enable,
    output logic             prefetch_read_enable,
    output logic             burst_write_enable,
    output logic             effective_byte_order,
    output logic      [3:0]  local_transaction_code,
    output tgi0_psize_e      destination_port_size,
    output logic             port_size_reserved,
    output logic      [31:0] window_bytes,
    output logic             pci_base_cfg_enable,
    output logic             pci_base_cfg_io_space
);

    logic        enable_r;
    logic        prefetch_r;
    logic        burstwr_r;
    logic        invert_r;
    logic [3:0]  tcode_r;
    logic [1:0]  psize_r;
    logic        postwr_r;
    logic [3:0]  blksz_r;
    logic        space_r;
    tgi0_half_t  base_r;
    tgi0_half_t  xlat_r;
    logic        loaded_r;
    logic        cfg_en_r;
    logic        strap_r;
    logic        field_wr_ok;
    logic        base_mirror;
    tgi0_half_t  base_eff;
    tgi0_half_t  cmp_mask;
    logic        wr_ctl;
    logic        wr_adr;
    logic [31:0] ctl_word;
    logic [31:0] adr_word;

    // Mask of upper address bits that take part in compare and translation.
    function automatic tgi0_half_t tgi0_mask(input logic [3:0] code);
        tgi0_half_t m;
        m = '1;
        for (int i = 0; i < 16; i++) begin
            if (i < int'(code)) begin
                m[i] = 1'b0;
            end
        end
        return m;
    endfunction : tgi0_mask

    function automatic logic tgi0_lane(input logic [3:0] be, input int bit_pos);
        return be[bit_pos / 8];
    endfunction : tgi0_lane

    assign wr_ctl = reg_wr && (reg_addr == `TGI0_OFS_CONTROL);
    assign wr_adr = reg_wr && (reg_addr == `TGI0_OFS_ADDRESS);

    // Strap is caught while PCI reset is held, never through the reset itself.
    always_ff @(posedge mclk) begin
        if (pci_rst) begin
            strap_r <= pci_disable_strap;
        end
    end

    // EEPROM load status belongs to the PCI reset domain of the image.
    always_ff @(posedge mclk) begin
        if (pci_rst) begin
            loaded_r <= `TGI0_RST_BIT;
            cfg_en_r <= `TGI0_RST_BIT;
        end else if (eeprom_load_strobe) begin
            loaded_r <= 1'b1;
            cfg_en_r <= eeprom_cfg_enable;
        end
    end

    assign field_wr_ok = !loaded_r || strap_r;
    assign base_mirror = cfg_en_r || strap_r;

    // Block size and space: PCI reset, EEPROM load, then guarded software write.
    always_ff @(posedge mclk) begin
        if (pci_rst) begin
            blksz_r <= `TGI0_RST_BLKSZ;
            space_r <= `TGI0_RST_BIT;
        end else if (eeprom_load_strobe) begin
            blksz_r <= eeprom_block_size_code;
            space_r <= eeprom_pci_address_space;
        end else if (wr_ctl && field_wr_ok) begin
            if (tgi0_lane(reg_be, `TGI0_CTL_BLKSZ_LO)) begin
                blksz_r <= reg_wdata[`TGI0_CTL_BLKSZ_HI:`TGI0_CTL_BLKSZ_LO];
            end
            if (tgi0_lane(reg_be, `TGI0_CTL_SPACE_BIT)) begin
                space_r <= reg_wdata[`TGI0_CTL_SPACE_BIT];
            end
        end
    end

    // General-reset settings, always writable.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            enable_r   <= `TGI0_RST_BIT;
            prefetch_r <= `TGI0_RST_BIT;
            burstwr_r  <= `TGI0_RST_BIT;
            invert_r   <= `TGI0_RST_BIT;
            tcode_r    <= `TGI0_RST_TCODE;
            psize_r    <= `TGI0_RST_PSIZE;
            postwr_r   <= `TGI0_RST_BIT;
        end else if (wr_ctl) begin
            if (tgi0_lane(reg_be, `TGI0_CTL_ENABLE_BIT)) begin
                enable_r <= reg_wdata[`TGI0_CTL_ENABLE_BIT];
            end
            if (tgi0_lane(reg_be, `TGI0_CTL_PREFETCH_BIT)) begin
                prefetch_r <= reg_wdata[`TGI0_CTL_PREFETCH_BIT];
                burstwr_r  <= reg_wdata[`TGI0_CTL_BURSTWR_BIT];
                invert_r   <= reg_wdata[`TGI0_CTL_INVERT_BIT];
            end
            if (tgi0_lane(reg_be, `TGI0_CTL_TCODE_LO)) begin
                tcode_r <= reg_wdata[`TGI0_CTL_TCODE_HI:`TGI0_CTL_TCODE_LO];
                psize_r <= reg_wdata[`TGI0_CTL_PSIZE_HI:`TGI0_CTL_PSIZE_LO];
            end
            if (tgi0_lane(reg_be, `TGI0_CTL_POSTWR_BIT)) begin
                postwr_r <= reg_wdata[`TGI0_CTL_POSTWR_BIT];
            end
        end
    end

    // Base address: PCI reset domain, writable only when no mirror exists.
    always_ff @(posedge mclk) begin
        if (pci_rst) begin
            base_r <= `TGI0_RST_HALF;
        end else if (wr_adr && !base_mirror) begin
            if (reg_be[3]) begin
                base_r[15:8] <= reg_wdata[31:24];
            end
            if (reg_be[2]) begin
                base_r[7:0] <= reg_wdata[23:16];
            end
        end
    end

    // Translation address is a general-reset setting; the EEPROM never touches it.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            xlat_r <= `TGI0_RST_HALF;
        end else if (wr_adr) begin
            if (reg_be[1]) begin
                xlat_r[15:8] <= reg_wdata[15:8];
            end
            if (reg_be[0]) begin
                xlat_r[7:0] <= reg_wdata[7:0];
            end
        end
    end

    assign base_eff = base_mirror ? pci_base_addr_cfg0 : base_r;

    always_comb begin
        ctl_word = `TGI0_RST_WORD;
        ctl_word[`TGI0_CTL_ENABLE_BIT]                      = enable_r;
        ctl_word[`TGI0_CTL_BLKSZ_HI:`TGI0_CTL_BLKSZ_LO]     = blksz_r;
        ctl_word[`TGI0_CTL_PREFETCH_BIT]                    = prefetch_r;
        ctl_word[`TGI0_CTL_BURSTWR_BIT]                     = burstwr_r;
        ctl_word[`TGI0_CTL_INVERT_BIT]                      = invert_r;
        ctl_word[`TGI0_CTL_TCODE_HI:`TGI0_CTL_TCODE_LO]     = tcode_r;
        ctl_word[`TGI0_CTL_PSIZE_HI:`TGI0_CTL_PSIZE_LO]     = psize_r;
        ctl_word[`TGI0_CTL_POSTWR_BIT]                      = postwr_r;
        ctl_word[`TGI0_CTL_SPACE_BIT]                       = space_r;
    end

    assign adr_word = {base_eff, xlat_r};

    // Reads answer one cycle later; unmapped offsets read as zero.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata  <= `TGI0_RST_WORD;
            reg_rvalid <= `TGI0_RST_BIT;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `TGI0_OFS_CONTROL: reg_rdata <= ctl_word;
                    `TGI0_OFS_ADDRESS: reg_rdata <= adr_word;
                    default:           reg_rdata <= `TGI0_RST_WORD;
                endcase
            end
        end
    end

    // Decode is combinational so the PCI side sees a hit in the address phase.
    assign cmp_mask = tgi0_mask(blksz_r);
    assign image_hit = pci_addr_valid && enable_r && (pci_io_cycle == space_r)
        && (((pci_addr[31:16] ^ base_eff) & cmp_mask) == `TGI0_RST_HALF);

    // Compared lines are replaced by translation bits; software keeps them equal for none.
    assign local_addr = {(xlat_r & cmp_mask) | (pci_addr[31:16] & ~cmp_mask),
                         pci_addr[15:0]};

    // I/O writes are never posted, whatever the posting bit says.
    assign post_write_ok = image_hit && pci_write_cycle && postwr_r && !space_r;

    assign window_bytes = 32'h1 << (`TGI0_MIN_WIN_SHIFT + int'(blksz_r));

    assign image_enable           = enable_r;
    assign prefetch_read_enable   = prefetch_r;
    assign burst_write_enable     = burstwr_r;
    assign effective_byte_order   = local_byte_order_setting ^ invert_r;
    assign local_transaction_code = tcode_r;
    assign destination_port_size  = tgi0_psize_e'(psize_r);
    assign port_size_reserved     = (psize_r == TGI0_PORT_RSVD);

    // The config-space base register exists only when loaded or strapped.
    assign pci_base_cfg_enable   = base_mirror;
    assign pci_base_cfg_io_space = space_r;

endmodule : tgi0_regs
`default_nettype wire

// ==== tgi0_asserts.sv ====
`default_nettype none
module tgi0_chk
    import tgi0_pkg::*;
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        local_byte_order_setting,
    input wire logic        effective_byte_order,
    input wire tgi0_psize_e destination_port_size,
    input wire logic        port_size_reserved,
    input wire logic        post_write_ok,
    input wire logic        image_hit,
    input wire logic        pci_write_cycle,
    input wire logic        pci_io_cycle,
    input wire logic [31:0] pci_addr,
    input wire logic [31:0] local_addr,
    input wire logic        image_enable,
    input wire logic [3:0]  local_transaction_code,
    input wire logic [31:0] window_bytes
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    AST_WINDOW: assert property (window_bytes >= 32'h0001_0000 && $onehot(window_bytes))
        else $error("window size not a power of two");
    // A write may flip the invert bit at the same edge, so only quiet cycles are judged.
    AST_ENDIAN: assert property (
        !$past(reg_wr) && !$past(sys_rst) && $changed(local_byte_order_setting)
        |-> $changed(effective_byte_order)) else $error("byte order did not follow");
    AST_RSVD: assert property (port_size_reserved == (destination_port_size == TGI0_PORT_RSVD))
        else $error("reserved port size flag wrong");
    AST_POST: assert property (post_write_ok |-> image_hit && pci_write_cycle && !pci_io_cycle)
        else $error("bad posted write");
    AST_HITEN: assert property (image_hit |-> image_enable)
        else $error("hit while disabled");
    AST_LOWADR: assert property (local_addr[15:0] == pci_addr[15:0])
        else $error("low address bits translated");
    AST_RVALID: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
        else $error("read valid timing wrong");
    AST_UNMAP: assert property (
        reg_rd && reg_addr != 12'h100 && reg_addr != 12'h104 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CTLRSV: assert property (
        reg_rd && reg_addr == 12'h100 |=> (reg_rdata & 32'h702f_033f) == 32'h0)
        else $error("reserved control bits set");
    AST_GRST: assert property (
        $fell(sys_rst) |-> !image_enable && local_transaction_code == 4'h0)
        else $error("general reset left settings");
    COV_HIT: cover property (image_hit);
    COV_POST: cover property (post_write_ok);
    COV_RSVD: cover property (port_size_reserved);
endmodule : tgi0_chk
bind tgi0_regs tgi0_chk u_tgi0_chk (.*);
`default_nettype wire

// ==== tgi0_ee_model.sv ====
`default_nettype none
module tgi0_ee_model (
    input  wire logic       mclk,
    input  wire logic       pci_rst,
    input  wire logic       present,
    input  wire logic [5:0] image_bits,
    output logic            load_strobe,
    output logic [5:0]      load_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        load_strobe = 1'b0;
        load_bits = 6'h00;
        forever begin
            @(negedge pci_rst);
            repeat (2) @(posedge mclk);
            #1;
            if (present) begin
                load_strobe = 1'b1;
                load_bits = image_bits;
                @(posedge mclk);
                #1;
                load_strobe = 1'b0;
            end
            // Lines carry no meaning outside the strobe, so stale data must not look valid.
            load_bits = ~load_bits;
        end
    end
endmodule : tgi0_ee_model
`default_nettype wire

// ==== tgi0_regs_tb.sv ====
`default_nettype none
module tgi0_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tgi0_pkg::*;
    logic mclk, sys_rst, pci_rst, pci_disable_strap, eeprom_load_strobe, present;
    logic eeprom_pci_address_space, eeprom_cfg_enable, local_byte_order_setting, reg_wr, reg_rd;
    logic pci_addr_valid, pci_io_cycle, pci_write_cycle, image_hit, post_write_ok, reg_rvalid;
    logic image_enable, prefetch_read_enable, burst_write_enable, effective_byte_order;
    logic port_size_reserved, pci_base_cfg_enable, pci_base_cfg_io_space;
    logic [3:0]  eeprom_block_size_code, reg_be, local_transaction_code;
    logic [5:0]  ee_bits;
    logic [11:0] reg_addr;
    logic [15:0] pci_base_addr_cfg0, b, t;
    logic [31:0] reg_wdata, reg_rdata, pci_addr, local_addr, window_bytes, a, m;
    tgi0_psize_e destination_port_size;
    logic [31:0] expq[$];
    int          bad_count, comparisons;
    tgi0_regs u_tgi0_regs (.*);
    tgi0_ee_model u_tgi0_ee_model (.mclk(mclk), .pci_rst(pci_rst), .present(present),
        .image_bits(ee_bits), .load_strobe(eeprom_load_strobe),
        .load_bits({eeprom_cfg_enable, eeprom_pci_address_space, eeprom_block_size_code}));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    // A read carries its expected word; the monitor below compares it.
    task automatic acc(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge mclk);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = ad;
        reg_wdata = d;
        if (!wr) expq.push_back(d);
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask : acc
    task automatic rst(input logic s, input logic p, input logic st, input logic pr);
        @(posedge mclk);
        #1;
        {sys_rst, pci_rst, pci_disable_strap, present} = {s, p, st, pr};
        repeat (3) @(posedge mclk);
        #1;
        {sys_rst, pci_rst} = 2'b00;
        repeat (4) @(posedge mclk);
    endtask : rst
    task automatic dec(input logic [31:0] ad, input logic io, input logic h, input logic p);
        @(posedge mclk);
        #1;
        {pci_addr, pci_io_cycle, pci_write_cycle, pci_addr_valid} = {ad, io, 2'b11};
        #1;
        chk(image_hit, h);
        chk(post_write_ok, p);
    endtask : dec
    always @(posedge mclk) begin
        if (reg_rvalid === 1'b1) chk(reg_rdata, expq.pop_front());
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h63dc));
        {sys_rst, pci_rst, pci_disable_strap, present, reg_wr, reg_rd} = 6'h30;
        {reg_addr, reg_wdata, pci_addr, reg_be, ee_bits} = {76'h0, 4'hf, 6'h0};
        {pci_addr_valid, pci_io_cycle, pci_write_cycle, local_byte_order_setting} = 4'h0;
        pci_base_addr_cfg0 = 16'($urandom);
        rst(1'b1, 1'b1, 1'b0, 1'b0);
        acc(1'b0, 12'h100, 32'h0);
        acc(1'b0, 12'h104, 32'h0);
        chk(pci_base_cfg_enable, 1'b0);
        acc(1'b1, 12'h100, 32'hffff_ffff);
        acc(1'b0, 12'h100, 32'h8fd0_fcc0);
        chk(image_enable, 1'b1);
        chk(prefetch_read_enable, 1'b1);
        chk(burst_write_enable, 1'b1);
        reg_be = 4'h8;
        acc(1'b1, 12'h100, 32'h0);
        reg_be = 4'hf;
        acc(1'b0, 12'h100, 32'h00d0_fcc0);
        acc(1'b0, 12'h0fc, 32'h0);
        for (int i = 0; i < 16; i++) begin
            acc(1'b1, 12'h100, {4'h0, i[3:0], 8'h10, i[3:0], i[1:0], 10'h0});
            chk(window_bytes, 32'h0001_0000 << i);
            chk(local_transaction_code, i[3:0]);
            chk(destination_port_size, i[1:0]);
            chk(port_size_reserved, i[1:0] == 2'h3);
            // The order flips one quiet cycle after the write, so the order check can judge it.
            @(posedge mclk);
            #1;
            local_byte_order_setting = i[0];
            #1;
            chk(effective_byte_order, !i[0]);
        end
        repeat (2) @(posedge mclk);
        #1;
        local_byte_order_setting = 1'b1;
        {b, t} = $urandom;
        a = $urandom;
        acc(1'b1, 12'h104, {b, t});
        acc(1'b1, 12'h100, {4'h8, a[3:0], 24'h80});
        chk(effective_byte_order, 1'b1);
        m = 32'hffff_ffff << (16 + a[3:0]);
        a = {b, 16'h0} ^ ($urandom & ~m);
        dec(a, 1'b0, 1'b1, 1'b1);
        chk(local_addr, ({t, 16'h0} & m) | (a & ~m));
        dec(a ^ 32'h8000_0000, 1'b0, 1'b0, 1'b0);
        dec(a, 1'b1, 1'b0, 1'b0);
        acc(1'b1, 12'h104, {b, b});
        dec(a, 1'b0, 1'b1, 1'b1);
        chk(local_addr, a);
        acc(1'b1, 12'h100, {4'h8, 4'hf, 24'hc0});
        dec(a, 1'b1, 1'b1, 1'b0);
        rst(1'b1, 1'b0, 1'b0, 1'b0);
        acc(1'b0, 12'h104, {b, 16'h0});
        dec(a, 1'b1, 1'b0, 1'b0);
        ee_bits = 6'h33;
        rst(1'b1, 1'b1, 1'b0, 1'b1);
        acc(1'b1, 12'h100, 32'h0700_0000);
        acc(1'b0, 12'h100, 32'h0300_0040);
        chk(pci_base_cfg_io_space, 1'b1);
        chk(pci_base_cfg_enable, 1'b1);
        acc(1'b1, 12'h104, 32'h1234_5678);
        acc(1'b0, 12'h104, {pci_base_addr_cfg0, 16'h5678});
        rst(1'b1, 1'b1, 1'b1, 1'b1);
        acc(1'b1, 12'h100, 32'h0700_0000);
        acc(1'b0, 12'h100, 32'h0700_0000);
        repeat (3) @(posedge mclk);
        chk(expq.size(), 32'h0);
        stop_test();
    end
endmodule : tgi0_regs_tb
`default_nettype wire
